// File: hw/tx_stats_defines.vh
// Register indices, field positions and reset values of the transmit statistics block
`ifndef TX_STATS_DEFINES_VH
`define TX_STATS_DEFINES_VH

// Register indices; the byte address is four times the index
`define IDX_TX_STATS_REVISION    12'h840
`define IDX_TX_STATS_SCRATCH     12'h841
`define IDX_TX_STATS_IDENT_WORD0 12'h842
`define IDX_TX_STATS_IDENT_WORD1 12'h843
`define IDX_TX_STATS_IDENT_WORD2 12'h844
`define IDX_TX_COUNTER_CONFIG    12'h845
`define IDX_TX_COUNTER_STATUS    12'h846
`define IDX_TX_IRQ_STATUS        12'h850
`define IDX_TX_IRQ_MASK          12'h851
`define IDX_TX_GOOD_OCTETS_LOW   12'h860
`define IDX_TX_GOOD_OCTETS_HIGH  12'h861

// Index field of the byte address
`define ADDR_IDX_MSB 13
`define ADDR_IDX_LSB 2

// Configuration fields
`define CFG_CLEAR_ALL_BIT    0
`define CFG_PARITY_CLR_BIT   1
`define CFG_SNAPSHOT_BIT     2

// Status fields
`define STAT_PARITY_BIT      0
`define STAT_PAUSED_BIT      1

// Interrupt event fields
`define IRQ_PARITY_BIT       0
`define IRQ_CARRY_BIT        1
`define IRQ_WIDTH            2

// Reset values
`define RST_SCRATCH          32'h00000008
`define RST_IRQ_MASK         2'h0

// Identification values (arbitrary, neutral)
`define ID_REVISION          32'h00000001
`define ID_WORD0             32'h54785374
`define ID_WORD1             32'h61747344
`define ID_WORD2             32'h656D6F31

`endif

// File: hw/tx_octet_counter.v
// 64-bit good-octet counter with snapshot copy and parity check
`timescale 1ns/1ps
`default_nettype none

module tx_octet_counter (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // Control
   input  wire        clear,
   input  wire        capture,
   input  wire        freeze,
   // Increment bus
   input  wire [15:0] increment,
   input  wire        strobe,
   // Results
   output wire [63:0] view,
   output reg         parity_fault,
   output reg         low_carry
);

   reg  [63:0] count;
   reg  [63:0] shadow;
   reg         parity;
   wire [32:0] low_sum;
   wire [63:0] next_count;

   assign low_sum = {1'b0, count[31:0]} + {17'h00000, increment};
   assign next_count = clear ? 64'h0000000000000000 :
                       strobe ? count + {48'h000000000000, increment} : count;

   // Reads see the copy while frozen, the running count otherwise
   assign view = freeze ? shadow : count;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count        <= 64'h0000000000000000;
         shadow       <= 64'h0000000000000000;
         parity       <= 1'b0;
         parity_fault <= 1'b0;
         low_carry    <= 1'b0;
      end else if (ce) begin
         count        <= next_count;
         parity       <= ^next_count;
         parity_fault <= (^count) != parity;
         low_carry    <= !clear && strobe && low_sum[32];
         if (capture) begin
            shadow <= count;
         end
      end
   end

endmodule

`default_nettype wire

// File: hw/tx_stats_regs.v
// AHB-Lite register bank of the transmit statistics block
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "tx_stats_defines.vh"

module tx_stats_regs (
   // Clock, reset and clock enable
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // Increment bus from the transmit datapath
   input  wire [15:0] good_octet_increment,
   input  wire        good_octet_increment_strobe,
   // Interrupt
   output wire        irq
);

   localparam [1:0] ST_IDLE      = 2'h0;
   localparam [1:0] ST_WRITE     = 2'h1;
   localparam [1:0] ST_READ      = 2'h2;
   localparam [1:0] ST_READ_DONE = 2'h3;

   reg  [1:0]  state;
   reg  [1:0]  next_state;
   reg  [11:0] addr_idx;
   reg  [31:0] scratch;
   reg         snapshot;
   reg         clear_all;
   reg         parity_clr;
   reg         parity_flag;
   reg  [`IRQ_WIDTH-1:0] irq_status;
   reg  [`IRQ_WIDTH-1:0] irq_mask;
   reg  [31:0] read_value;

   wire        accept;
   wire        write_now;
   wire        cfg_write;
   wire        capture;
   wire [63:0] octet_view;
   wire        parity_fault;
   wire        low_carry;
   wire [`IRQ_WIDTH-1:0] irq_events;
   wire        scratch_write;
   wire        irq_status_write;
   wire        irq_mask_write;
   wire [31:0] config_word;
   wire [31:0] status_word;
   wire [31:0] irq_status_word;
   wire [31:0] irq_mask_word;
   wire [31:0] octets_low_word;
   wire [31:0] octets_high_word;

   // Index test for the captured address
   function is_reg;
      input [11:0] idx;
      input [11:0] target;
      begin
         is_reg = (idx == target);
      end
   endfunction

   // Widen an interrupt field to a bus word; the upper bits read zero
   function [31:0] irq_word;
      input [`IRQ_WIDTH-1:0] bits;
      begin
         irq_word = {{(32-`IRQ_WIDTH){1'b0}}, bits};
      end
   endfunction

   // Configuration word as read back; bits above the snapshot bit are reserved
   function [31:0] config_fields;
      input snap;
      input pclr;
      input clr;
      begin
         config_fields = {29'h00000000, snap, pclr, clr};
      end
   endfunction

   // Status word: paused indicator above the sticky parity flag
   function [31:0] status_fields;
      input paused;
      input flag;
      begin
         status_fields = {30'h00000000, paused, flag};
      end
   endfunction

   // Bus handshake
   assign accept    = hsel && htrans[1] && hready && ce;
   assign write_now = (state == ST_WRITE) && ce;
   assign hreadyout = ce && (state != ST_READ);
   assign hresp     = 1'b0;

   assign cfg_write = write_now && is_reg(addr_idx, `IDX_TX_COUNTER_CONFIG);
   // Capture only on the rising edge of the snapshot bit
   assign capture   = cfg_write && hwdata[`CFG_SNAPSHOT_BIT] && !snapshot;

   // Write strobes of the other writable registers
   assign scratch_write    = write_now && is_reg(addr_idx, `IDX_TX_STATS_SCRATCH);
   assign irq_status_write = write_now && is_reg(addr_idx, `IDX_TX_IRQ_STATUS);
   assign irq_mask_write   = write_now && is_reg(addr_idx, `IDX_TX_IRQ_MASK);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_state = hwrite ? ST_WRITE : ST_READ;
            end else begin
               next_state = ST_IDLE;
            end
         end
         // Read data stands here; a new address phase may overlap it
         ST_READ_DONE: begin
            if (accept) begin
               next_state = hwrite ? ST_WRITE : ST_READ;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (accept) begin
               next_state = hwrite ? ST_WRITE : ST_READ;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_READ: begin
            next_state = ST_READ_DONE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Register index of the transfer in its data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_idx <= 12'h000;
      end else if (accept) begin
         addr_idx <= haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
      end
   end

   // Good-octet counter
   tx_octet_counter u_octets (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .ce           (ce),
      .clear        (clear_all),
      .capture      (capture),
      .freeze       (snapshot),
      .increment    (good_octet_increment),
      .strobe       (good_octet_increment_strobe),
      .view         (octet_view),
      .parity_fault (parity_fault),
      .low_carry    (low_carry)
   );

   // Scratch register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scratch <= `RST_SCRATCH;
      end else if (ce && scratch_write) begin
         scratch <= hwdata;
      end
   end

   // Snapshot request; the counter takes its copy on the rising edge
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snapshot <= 1'b0;
      end else if (ce && cfg_write) begin
         snapshot <= hwdata[`CFG_SNAPSHOT_BIT];
      end
   end

   // Clear-all pulse; upper configuration bits are not stored
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clear_all <= 1'b0;
      end else if (ce) begin
         clear_all <= cfg_write && hwdata[`CFG_CLEAR_ALL_BIT];
      end
   end

   // Parity-clear pulse
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         parity_clr <= 1'b0;
      end else if (ce) begin
         parity_clr <= cfg_write && hwdata[`CFG_PARITY_CLR_BIT];
      end
   end

   // Sticky parity flag; a fault in the clearing cycle keeps it set
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         parity_flag <= 1'b0;
      end else if (ce) begin
         if (parity_fault) begin
            parity_flag <= 1'b1;
         end else if (parity_clr) begin
            parity_flag <= 1'b0;
         end
      end
   end

   // Interrupt events: parity fault and carry out of the low counter word
   assign irq_events = {low_carry, parity_fault};

   // Sticky interrupt status, write one to clear; a new event wins over the clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= {`IRQ_WIDTH{1'b0}};
      end else if (ce) begin
         if (irq_status_write) begin
            irq_status <= (irq_status & ~hwdata[`IRQ_WIDTH-1:0]) | irq_events;
         end else begin
            irq_status <= irq_status | irq_events;
         end
      end
   end

   // Interrupt mask, same layout as the status
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask <= `RST_IRQ_MASK;
      end else if (ce && irq_mask_write) begin
         irq_mask <= hwdata[`IRQ_WIDTH-1:0];
      end
   end

   // Level interrupt while any unmasked status bit is set
   assign irq = |(irq_status & irq_mask);

   // Read words of the composite registers
   assign config_word      = config_fields(snapshot, parity_clr, clear_all);
   assign status_word      = status_fields(snapshot, parity_flag);
   assign irq_status_word  = irq_word(irq_status);
   assign irq_mask_word    = irq_word(irq_mask);
   assign octets_low_word  = octet_view[31:0];
   assign octets_high_word = octet_view[63:32];

   // Read multiplexer
   always @* begin
      read_value = 32'h00000000;
      case (addr_idx)
         `IDX_TX_STATS_REVISION: begin
            read_value = `ID_REVISION;
         end
         `IDX_TX_STATS_SCRATCH: begin
            read_value = scratch;
         end
         `IDX_TX_STATS_IDENT_WORD0: begin
            read_value = `ID_WORD0;
         end
         `IDX_TX_STATS_IDENT_WORD1: begin
            read_value = `ID_WORD1;
         end
         `IDX_TX_STATS_IDENT_WORD2: begin
            read_value = `ID_WORD2;
         end
         `IDX_TX_COUNTER_CONFIG: begin
            read_value = config_word;
         end
         `IDX_TX_COUNTER_STATUS: begin
            read_value = status_word;
         end
         `IDX_TX_IRQ_STATUS: begin
            read_value = irq_status_word;
         end
         `IDX_TX_IRQ_MASK: begin
            read_value = irq_mask_word;
         end
         `IDX_TX_GOOD_OCTETS_LOW: begin
            read_value = octets_low_word;
         end
         `IDX_TX_GOOD_OCTETS_HIGH: begin
            read_value = octets_high_word;
         end
         default: begin
            read_value = 32'h00000000;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ce && state == ST_READ) begin
         hrdata <= read_value;
      end
   end

endmodule

`default_nettype wire

// File: verification/tx_stats_regs_asserts.sv
// Assertion checker for the transmit statistics register bank
`timescale 1ns/1ps
`default_nettype none
`include "tx_stats_defines.vh"
module tx_stats_regs_chk (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // Bus
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   // Increment strobe and interrupt
   input  wire logic        good_octet_increment_strobe,
   input  wire logic        irq
);
   logic        av;
   logic        aw;
   logic        snap;
   logic        clr;
   logic [11:0] ai;
   logic [31:0] scr;
   logic [1:0]  msk;
   wire         wr = av && aw && hreadyout;
   wire         rd = av && !aw && hreadyout;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Shadow of the data phase and of the writable state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         av   <= 1'b0;
         aw   <= 1'b0;
         ai   <= 12'h000;
         snap <= 1'b0;
         clr  <= 1'b0;
         scr  <= `RST_SCRATCH;
         msk  <= `RST_IRQ_MASK;
      end else begin
         if (hready) begin
            av <= hsel && htrans[1] && ce;
            aw <= hwrite;
            ai <= haddr[13:2];
         end
         if (wr && ai == `IDX_TX_STATS_SCRATCH) scr <= hwdata;
         if (wr && ai == `IDX_TX_IRQ_MASK) msk <= hwdata[1:0];
         if (wr && ai == `IDX_TX_COUNTER_CONFIG) snap <= hwdata[2];
         if (wr && ai == `IDX_TX_COUNTER_CONFIG) clr <= hwdata[0] && !hwdata[2] && !snap;
         else if (good_octet_increment_strobe && ce) clr <= 1'b0;
      end
   end
   sequence rd_start;
      hsel && htrans[1] && hready && ce && !hwrite;
   endsequence
   sequence one_wait;
      !hreadyout ##1 (!ce || hreadyout);
   endsequence
   AST_READ_WAIT: assert property (rd_start ##1 ce |-> one_wait)
      else $error("read wait state wrong");
   AST_SCRATCH: assert property (rd && ai == `IDX_TX_STATS_SCRATCH |-> hrdata == scr)
      else $error("scratch read mismatch");
   AST_REVISION: assert property (rd && ai == `IDX_TX_STATS_REVISION |-> hrdata == `ID_REVISION)
      else $error("revision read mismatch");
   AST_IDENT: assert property (rd && ai >= `IDX_TX_STATS_IDENT_WORD0 && ai <= `IDX_TX_STATS_IDENT_WORD2
      |-> hrdata == (ai == `IDX_TX_STATS_IDENT_WORD0 ? `ID_WORD0 :
                     ai == `IDX_TX_STATS_IDENT_WORD1 ? `ID_WORD1 : `ID_WORD2))
      else $error("ident read mismatch");
   AST_CFG_BITS: assert property (rd && ai == `IDX_TX_COUNTER_CONFIG |-> hrdata[31:2] == {29'h0, snap})
      else $error("config read mismatch");
   AST_STAT_RSVD: assert property (rd && ai == `IDX_TX_COUNTER_STATUS |-> hrdata[31:2] == 30'h0)
      else $error("status reserved bits set");
   AST_PAUSED: assert property (rd && ai == `IDX_TX_COUNTER_STATUS |-> hrdata[1] == snap)
      else $error("paused bit mismatch");
   AST_CLEARED: assert property (rd && clr && ai[11:1] == 11'h430 |-> hrdata == 32'h0)
      else $error("counter not cleared");
   AST_IRQ_MASKED: assert property (msk == 2'h0 |-> !irq)
      else $error("irq while masked");
   AST_OKAY: assert property (!hresp)
      else $error("error response seen");
endmodule
bind tx_stats_regs tx_stats_regs_chk u_chk (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .good_octet_increment_strobe, .irq);
`default_nettype wire

// File: verification/tx_datapath_model.sv
// Transmit datapath model driving the good-octet increment bus
`timescale 1ns/1ps
`default_nettype none
module tx_datapath_model (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Request from the bench
   input  wire logic        send,
   input  wire logic [15:0] count,
   // Increment bus
   output var  logic [15:0] good_octet_increment,
   output var  logic        good_octet_increment_strobe
);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         good_octet_increment        <= 16'h0000;
         good_octet_increment_strobe <= 1'b0;
      end else begin
         good_octet_increment_strobe <= send;
         // Idle cycles carry a changing value that must not be counted
         good_octet_increment        <= send ? count : ~good_octet_increment;
      end
   end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking testbench of the transmit statistics register bank
`timescale 1ns/1ps
`default_nettype none
`include "tx_stats_defines.vh"
module testbench;
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        irq;
   logic        send;
   logic        good_octet_increment_strobe;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] count;
   logic [15:0] good_octet_increment;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] seed;
   logic [31:0] snapv;
   logic [63:0] cnt;
   int          num_errors;
   int          compares;
   tx_stats_regs DUT (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .good_octet_increment,
      .good_octet_increment_strobe, .irq);
   tx_datapath_model partner (.hclk, .hresetn, .send, .count, .good_octet_increment,
      .good_octet_increment_strobe);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   always @(posedge hclk) begin
      if (hresetn && ce && good_octet_increment_strobe) begin
         cnt <= cnt + {48'h0, good_octet_increment};
      end
   end
   task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] d,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {18'h0, i, 2'h0};
      @(posedge hclk iff hreadyout);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk iff hreadyout);
      r = hrdata;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdc(input string n, input logic [11:0] i, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, i, 32'h0, r);
      chk(n, e, r);
   endtask
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, i, d, r);
   endtask
   // Random gaps and sizes unless the full size is asked for
   task automatic run(input int n, input logic full);
      repeat (n) begin
         send  <= full | seed[16];
         count <= full ? 16'hFFFF : seed[15:0];
         seed = lfsr(seed);
         @(posedge hclk);
      end
      send <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (80000) @(posedge hclk);
      num_errors++;
      conclude();
   end
   initial begin
      {hresetn, hsel, hwrite, send, htrans, count, haddr, hwdata, cnt} = '0;
      hsize = 3'h2;
      ce    = 1'b1;
      seed  = 32'h4286;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc("scratch", `IDX_TX_STATS_SCRATCH, `RST_SCRATCH);
      rdc("revision", `IDX_TX_STATS_REVISION, `ID_REVISION);
      rdc("ident0", `IDX_TX_STATS_IDENT_WORD0, `ID_WORD0);
      rdc("ident1", `IDX_TX_STATS_IDENT_WORD1, `ID_WORD1);
      rdc("ident2", `IDX_TX_STATS_IDENT_WORD2, `ID_WORD2);
      rdc("unmapped", 12'h900, 32'h0);
      $display("test reset values done");
      wr(`IDX_TX_STATS_SCRATCH, seed);
      rdc("scratch", `IDX_TX_STATS_SCRATCH, seed);
      wr(`IDX_TX_COUNTER_CONFIG, 32'hFFFFFFF8);
      rdc("config", `IDX_TX_COUNTER_CONFIG, 32'h0);
      wr(`IDX_TX_COUNTER_STATUS, 32'hFFFFFFFF);
      rdc("status", `IDX_TX_COUNTER_STATUS, 32'h0);
      wr(`IDX_TX_STATS_REVISION, 32'h0);
      rdc("revision", `IDX_TX_STATS_REVISION, `ID_REVISION);
      $display("test access kinds done");
      run(200, 1'b0);
      rdc("octets low", `IDX_TX_GOOD_OCTETS_LOW, cnt[31:0]);
      rdc("octets high", `IDX_TX_GOOD_OCTETS_HIGH, cnt[63:32]);
      wr(`IDX_TX_COUNTER_CONFIG, 32'h4);
      snapv = cnt[31:0];
      rdc("status", `IDX_TX_COUNTER_STATUS, 32'h2);
      run(100, 1'b0);
      rdc("frozen low", `IDX_TX_GOOD_OCTETS_LOW, snapv);
      wr(`IDX_TX_COUNTER_CONFIG, 32'h0);
      rdc("live low", `IDX_TX_GOOD_OCTETS_LOW, cnt[31:0]);
      rdc("status", `IDX_TX_COUNTER_STATUS, 32'h0);
      $display("test snapshot done");
      // Increments offered while the enable is low must be lost
      ce <= 1'b0;
      run(20, 1'b0);
      ce <= 1'b1;
      rdc("enable low", `IDX_TX_GOOD_OCTETS_LOW, cnt[31:0]);
      $display("test clock enable done");
      wr(`IDX_TX_COUNTER_CONFIG, 32'h1);
      cnt = 64'h0;
      rdc("config", `IDX_TX_COUNTER_CONFIG, 32'h0);
      rdc("cleared low", `IDX_TX_GOOD_OCTETS_LOW, 32'h0);
      wr(`IDX_TX_COUNTER_CONFIG, 32'h2);
      rdc("config", `IDX_TX_COUNTER_CONFIG, 32'h0);
      rdc("status", `IDX_TX_COUNTER_STATUS, 32'h0);
      $display("test clear done");
      wr(`IDX_TX_IRQ_MASK, 32'h2);
      run(65540, 1'b1);
      chk("irq", {31'h0, cnt[63:32] != 0}, {31'h0, irq});
      rdc("octets high", `IDX_TX_GOOD_OCTETS_HIGH, cnt[63:32]);
      wr(`IDX_TX_IRQ_MASK, 32'h0);
      @(posedge hclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rdc("irq status", `IDX_TX_IRQ_STATUS, 32'h2);
      wr(`IDX_TX_IRQ_STATUS, 32'h2);
      rdc("irq status", `IDX_TX_IRQ_STATUS, 32'h0);
      $display("test interrupt done");
      conclude();
   end
endmodule
`default_nettype wire
